// [design/ddr_mode_regs.vh]
/*
 * Constants for the mode-feature logic: mode register field positions,
 * refresh mode codes and timing counts in 100 MHz core clocks.
 * Assumes inclusion by bare name from design files.
 */
`ifndef DDR_MODE_REGS_VH
`define DDR_MODE_REGS_VH

// ****************************************************
// Mode register addressing
// ****************************************************
`define MR_SEL_W          3
`define MR1_SEL           3'h1
`define MR2_SEL           3'h2
`define MR1_WLVL_BIT      7
`define MR1_CAL_LSB       0
`define MR1_CAL_W         3
`define MR2_SR_LSB        6

// ****************************************************
// Self refresh mode codes (bits [7:6])
// ****************************************************
`define SR_NORMAL         2'h0
`define SR_REDUCED        2'h1
`define SR_EXTENDED       2'h2
`define SR_AUTO           2'h3

// ****************************************************
// Timing, in ns, and derived core clock counts
// ****************************************************
`define CLK_PERIOD_NS     10
`define TWLO_NS           10
`define TMOD_NS           240
`define TWLO_CYC          ((`TWLO_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TMOD_CYC          ((`TMOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Temperature threshold codes for automatic refresh rate
`define TEMP_LOW          8'h2d
`define TEMP_HIGH         8'h55

`endif

// [design/edge_sync.v]
/*
 * Three-flop synchroniser for a signal from outside the clock domain.
 * Reports a level once the second and third flops agree, plus rise pulse.
 * Assumes clk is the core clock and reset is asynchronous active high.
 */
`timescale 1ns/1ns
`default_nettype none

module edge_sync (
    input  wire clk,
    input  wire reset,
    input  wire din,
    output reg  level_q,
    output reg  rise_q
);

    reg s1_q;
    reg s2_q;
    reg s3_q;

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            s1_q    <= 1'b0;
            s2_q    <= 1'b0;
            s3_q    <= 1'b0;
            level_q <= 1'b0;
            rise_q  <= 1'b0;
        end else begin
            s1_q   <= din;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            rise_q <= 1'b0;
            // Filtered level only moves when the last two stages agree
            if (s2_q == s3_q) begin
                level_q <= s3_q;
                rise_q  <= s3_q & ~level_q;
            end
        end
    end

endmodule // edge_sync

`default_nettype wire

// [design/ddr_mode_ctl.v]
/*
 * Device-side mode feature logic: write leveling feedback and exit,
 * command/address latency pipe, self refresh mode decode.
 * Assumes mode register writes arrive decoded from the command path,
 * and ck_in/dqs_in are pins from outside the core clock domain.
 */
`timescale 1ns/1ns
`default_nettype none
`include "ddr_mode_regs.vh"

// Contract
// - MR1 bit 7 set enters write leveling; cleared leaves it.
// - Clock level sampled on rising strobe, driven on all DQ after tWLO.
// - No read strobe accompanies the leveling feedback.
// - DQ undefined from strobe release until tMOD after leveling exit; code counts a strobe release only while ODT is low.
// - With CAL, command and address registered tCAL cycles after CS low.
// - Receivers may switch off after latch if CS high; stay on otherwise.
// - CAL leaves ODT timing relative to command bus unchanged.
// - Auto mode adapts self refresh rate to temperature.
// - Bits [7:6]: 00 normal, 10 extended, 01 reduced, 11 auto.
module ddr_mode_ctl #(
    parameter DQ_W  = 8,
    parameter CA_W  = 24,
    parameter CAL_W = `MR1_CAL_W
) (
    input  wire              clk,
    input  wire              reset,
    input  wire              mr_wr,
    input  wire [2:0]        mr_sel,
    input  wire [15:0]       mr_data,
    input  wire              ck_in,
    input  wire              dqs_in,
    input  wire              cs_n_in,
    input  wire [CA_W-1:0]   ca_in,
    input  wire              odt_in,
    input  wire              self_ref,
    input  wire [7:0]        temp,
    output reg  [DQ_W-1:0]   dq_out,
    output reg  [DQ_W-1:0]   dq_oe,
    output reg  [DQ_W-1:0]   dq_undef,
    output reg               dqs_oe,
    output reg               wlvl_q,
    output reg               ca_rx_en,
    output reg               cmd_valid,
    output reg  [CA_W-1:0]   cmd_ca,
    output reg               odt_q,
    output reg  [1:0]        sr_mode_q,
    output reg  [1:0]        sr_rate
);

    // ****************************************************
    // Pin synchronisers
    // ****************************************************
    wire ck_lvl;
    wire dqs_rise;
    wire dqs_lvl;

    edge_sync u_ck_sync (
        .clk     (clk),
        .reset   (reset),
        .din     (ck_in),
        .level_q (ck_lvl),
        .rise_q  ()
    );

    edge_sync u_dqs_sync (
        .clk     (clk),
        .reset   (reset),
        .din     (dqs_in),
        .level_q (dqs_lvl),
        .rise_q  (dqs_rise)
    );

    // ****************************************************
    // Mode registers
    // ****************************************************
    reg [CAL_W-1:0] cal_q;
    reg             exit_pend_q;
    reg [7:0]       undef_cnt_q;
    reg             strobe_seen_q;

    function is_mr;
        input       wr;
        input [2:0] sel;
        input [2:0] want;
        begin
            is_mr = wr & (sel == want);
        end
    endfunction

    wire mr1_wr = is_mr(mr_wr, mr_sel, `MR1_SEL);
    wire mr2_wr = is_mr(mr_wr, mr_sel, `MR2_SEL);

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            wlvl_q    <= 1'b0;
            cal_q     <= {CAL_W{1'b0}};
            sr_mode_q <= `SR_NORMAL;
        end else begin
            if (mr1_wr) begin
                wlvl_q <= mr_data[`MR1_WLVL_BIT];
                cal_q  <= mr_data[`MR1_CAL_LSB +: CAL_W];
            end
            // Mode may only move outside self refresh
            if (mr2_wr && !self_ref)
                sr_mode_q <= mr_data[`MR2_SR_LSB +: 2];
        end
    end

    // ****************************************************
    // Write leveling feedback
    // ****************************************************
    reg [7:0] wlo_cnt_q;
    reg       sample_q;

    // Counts fit the 8-bit counters; upper bits are dropped on purpose
    localparam [31:0] WLO_CYC = `TWLO_CYC;
    localparam [31:0] MOD_CYC = `TMOD_CYC;

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            sample_q      <= 1'b0;
            wlo_cnt_q     <= 8'h00;
            dq_out        <= {DQ_W{1'b0}};
            dq_oe         <= {DQ_W{1'b0}};
            dq_undef      <= {DQ_W{1'b0}};
            dqs_oe        <= 1'b0;
            exit_pend_q   <= 1'b0;
            undef_cnt_q   <= 8'h00;
            strobe_seen_q <= 1'b0;
        end else begin
            dqs_oe <= 1'b0;
            if (wlvl_q && dqs_rise) begin
                sample_q      <= ck_lvl;
                wlo_cnt_q     <= WLO_CYC[7:0];
                strobe_seen_q <= 1'b1;
            end else if (wlo_cnt_q != 8'h00) begin
                wlo_cnt_q <= wlo_cnt_q - 8'h01;
            end
            if (wlvl_q && wlo_cnt_q == 8'h01)
                dq_out <= {DQ_W{sample_q}};
            // Pins stay driven through the undefined window after exit
            dq_oe <= {DQ_W{wlvl_q || (undef_cnt_q != 8'h00)}};
            // Strobe released after edges: feedback no longer meaningful
            if (wlvl_q && strobe_seen_q && !dqs_lvl && !odt_in)
                exit_pend_q <= 1'b1;
            if (mr1_wr && !mr_data[`MR1_WLVL_BIT] && wlvl_q) begin
                undef_cnt_q <= MOD_CYC[7:0];
                exit_pend_q <= 1'b1;
            end else if (!wlvl_q && undef_cnt_q != 8'h00) begin
                undef_cnt_q <= undef_cnt_q - 8'h01;
            end else if (!wlvl_q) begin
                exit_pend_q   <= 1'b0;
                strobe_seen_q <= 1'b0;
            end
            dq_undef <= {DQ_W{exit_pend_q}};
        end
    end

    // ****************************************************
    // Command/address latency pipe
    // ****************************************************
    // The pipe carries each CS-low marker forward by cal_q cycles; CA is taken
    // directly from the pins in the cycle the marker matures.
    localparam PIPE = (1 << CAL_W);
    reg [PIPE-1:0] cs_pipe_q;
    wire           cs_now = ~cs_n_in;
    wire           cs_due = (cal_q == {CAL_W{1'b0}}) ? cs_now : cs_pipe_q[cal_q - 1'b1];

    genvar g;
    generate
        for (g = 0; g < PIPE; g = g + 1) begin : g_pipe
            if (g == 0) begin : g_head
                always @(posedge clk or posedge reset) begin
                    if (reset)
                        cs_pipe_q[g] <= 1'b0;
                    else
                        cs_pipe_q[g] <= cs_now;
                end
            end else begin : g_tail
                always @(posedge clk or posedge reset) begin
                    if (reset)
                        cs_pipe_q[g] <= 1'b0;
                    else
                        cs_pipe_q[g] <= cs_pipe_q[g-1];
                end
            end
        end
    endgenerate

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            cmd_valid <= 1'b0;
            cmd_ca    <= {CA_W{1'b0}};
            ca_rx_en  <= 1'b1;
            odt_q     <= 1'b0;
        end else begin
            cmd_valid <= cs_due;
            if (cs_due)
                cmd_ca <= ca_in;
            // Receivers rest only when no marker is in flight
            if (cal_q == {CAL_W{1'b0}})
                ca_rx_en <= 1'b1;
            else
                ca_rx_en <= cs_now | (|cs_pipe_q);
            odt_q <= odt_in;
        end
    end

    // ****************************************************
    // Self refresh rate selection
    // ****************************************************
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            sr_rate <= 2'h1;
        end else begin
            case (sr_mode_q)
                `SR_AUTO: begin
                    if (temp < `TEMP_LOW)
                        sr_rate <= 2'h0;
                    else if (temp > `TEMP_HIGH)
                        sr_rate <= 2'h2;
                    else
                        sr_rate <= 2'h1;
                end
                `SR_EXTENDED: sr_rate <= 2'h2;
                `SR_REDUCED:  sr_rate <= 2'h0;
                default:      sr_rate <= 2'h1;
            endcase
        end
    end

endmodule // ddr_mode_ctl

`default_nettype wire

// [testbench/ddr_mode_ctl_monitor.sv]
/* Port assertions for ddr_mode_ctl.
   Assumes binding onto ddr_mode_ctl; clk is the core clock, reset async. */
`timescale 1ns/1ns
`default_nettype none
module ddr_mode_ctl_monitor #(parameter DQ_W = 8, parameter CA_W = 24) (
    input wire logic            clk,
    input wire logic            reset,
    input wire logic            mr_wr,
    input wire logic [2:0]      mr_sel,
    input wire logic [15:0]     mr_data,
    input wire logic            cs_n_in,
    input wire logic [CA_W-1:0] ca_in,
    input wire logic            odt_in,
    input wire logic            self_ref,
    input wire logic [7:0]      temp,
    input wire logic [DQ_W-1:0] dq_out,
    input wire logic [DQ_W-1:0] dq_oe,
    input wire logic [DQ_W-1:0] dq_undef,
    input wire logic            dqs_oe,
    input wire logic            wlvl_q,
    input wire logic            cmd_valid,
    input wire logic [CA_W-1:0] cmd_ca,
    input wire logic            odt_q,
    input wire logic [1:0]      sr_mode_q,
    input wire logic [1:0]      sr_rate
);
    // ****
    // Helper: latency as last programmed
    // ****
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic [2:0] cal_q;
    wire        mr1 = mr_wr && mr_sel == 3'h1;
    always_ff @(posedge clk or posedge reset)
        if (reset) cal_q <= 3'h0;
        else if (mr1) cal_q <= mr_data[2:0];

    wlvl_on_a: assert property (mr1 && mr_data[7] |=> wlvl_q) else $error("leveling not entered");
    wlvl_off_a: assert property (mr1 && !mr_data[7] |=> !wlvl_q) else $error("leveling not left");
    no_strobe_a: assert property (dqs_oe == 1'b0) else $error("read strobe driven");
    dq_same_a: assert property (|dq_oe |-> dq_out == '0 || dq_out == '1) else $error("bits differ");
    cal_zero_a: assert property (!cs_n_in && cal_q == 3'h0 |=> cmd_valid && cmd_ca == $past(ca_in))
        else $error("command latency zero wrong");
    cal_three_a: assert property (!cs_n_in && cal_q == 3'h3 |-> ##4 cmd_valid && cmd_ca == $past(ca_in))
        else $error("command latency three wrong");
    odt_flat_a: assert property (1 ##1 1 |-> odt_q == $past(odt_in)) else $error("odt delay moved");
    sr_code_a: assert property (mr_wr && mr_sel == 3'h2 && !self_ref |=> sr_mode_q == $past(mr_data[7:6]))
        else $error("refresh mode code");
    sr_hold_a: assert property (self_ref |=> $stable(sr_mode_q)) else $error("mode changed in refresh");
    sr_cold_a: assert property ((sr_mode_q == 2'h3 && temp < 8'h2d) [*3] |-> sr_rate == 2'h0)
        else $error("cold rate");
    undef_a: assert property ($fell(wlvl_q) |-> dq_undef != '0 [*8] ##1 dq_undef != '0 [*8]
        ##[1:12] dq_undef == '0) else $error("undefined window length");
endmodule // ddr_mode_ctl_monitor
`default_nettype wire

// [testbench/ddr_ctl_model.sv]
/* Controller side pins: free running CK, leveling strobe, ODT.
   Assumes the bench calls strobe and term hierarchically. */
`timescale 1ns/1ns
`default_nettype none
module ddr_ctl_model (
    output var logic ck_in,
    output var logic dqs_in,
    output var logic odt_in
);
    // ****
    // Pins
    // ****
    initial begin
        ck_in = 1'b0;
        dqs_in = 1'b0;
        odt_in = 1'b0;
        forever begin
            #63 ck_in = 1'b1;
            #62 ck_in = 1'b0;
        end
    end
    // Strobe idles low between calls, one rising edge per call
    task automatic strobe(input int ofs);
        @(posedge ck_in);
        #(ofs) dqs_in = 1'b1;
        #40 dqs_in = 1'b0;
    endtask
    task automatic term(input logic on);
        odt_in <= on;
    endtask
endmodule // ddr_ctl_model
`default_nettype wire

// [testbench/ddr_mode_ctl_tb_top.sv]
/* Self-checking bench for ddr_mode_ctl with a controller pin model.
   Assumes design/ in the include path. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module ddr_mode_ctl_tb_top;
    localparam int DQ_W = 8;
    localparam int CA_W = 24;
    logic            clk, reset, mr_wr, cs_n_in, self_ref;
    logic [2:0]      mr_sel;
    logic [15:0]     mr_data;
    logic [CA_W-1:0] ca_in, exp_ca, exp_q[$];
    logic [7:0]      temp;
    wire logic       ck_in, dqs_in, odt_in, dqs_oe, wlvl_q, ca_rx_en, cmd_valid, odt_q;
    wire [DQ_W-1:0]  dq_out, dq_oe, dq_undef;
    wire [CA_W-1:0]  cmd_ca;
    wire [1:0]       sr_mode_q, sr_rate;
    int              errors, checks_done, cal, cyc, hi, ofs, lock_ofs, due[$];
    ddr_mode_ctl #(.DQ_W(DQ_W), .CA_W(CA_W)) DUT (.*);
    ddr_ctl_model model (.ck_in(ck_in), .dqs_in(dqs_in), .odt_in(odt_in));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ****
    // Reference model: command pipe of cal cycles
    // ****
    always @(posedge clk) begin
        cyc++;
        if (cmd_valid === 1'b1) begin
            exp_ca = exp_q.size() ? exp_q.pop_front() : 'x;
            `CHK(cmd_ca, exp_ca)
        end
        if (!reset && !cs_n_in) due.push_back(cyc + cal);
        // Receivers must be on in the cycle the command is latched
        if (due.size() && due[0] == cyc) begin
            exp_q.push_back(ca_in);
            void'(due.pop_front());
            `CHK(ca_rx_en, 1'b1)
        end
    end
    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic mrw(input logic [2:0] s, input logic [15:0] d);
        mr_wr <= 1'b1; mr_sel <= s; mr_data <= d;
        @(posedge clk);
        mr_wr <= 1'b0;
        if (s == 3'h1) cal = d[2:0];
        @(posedge clk);
    endtask
    // New latency applies to the wait after a mode write
    task automatic gap;
        repeat (25 + cal) @(posedge clk);
    endtask
    task automatic cmds(input int n);
        repeat (n) begin
            cs_n_in <= 1'b0; ca_in <= $urandom;
            @(posedge clk);
        end
        cs_n_in <= 1'b1;
        repeat (cal + 4) begin ca_in <= $urandom; @(posedge clk); end
        `CHK(exp_q.size() + due.size(), 0)
    endtask
    initial begin
        reset = 1'b1; mr_wr = 1'b0; mr_sel = 3'h0; mr_data = 16'h0;
        cs_n_in = 1'b1; ca_in = '0; self_ref = 1'b0; temp = 8'h0;
        void'($urandom(32'h8175));
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        `CHK({wlvl_q, ca_rx_en, sr_rate, sr_mode_q, dq_oe}, {4'h5, 2'h0, {DQ_W{1'b0}}})
        for (int m = 0; m < 4; m++) begin
            mrw(3'h2, 16'(m << 6)); `CHK(sr_mode_q, 2'(m))
            self_ref <= 1'b1; mrw(3'h2, 16'((3 - m) << 6)); `CHK(sr_mode_q, 2'(m))
            self_ref <= 1'b0;
        end
        temp <= 8'($urandom % 45); repeat (5) @(posedge clk); `CHK(sr_rate, 2'h0)
        temp <= 8'h56 + 8'($urandom % 160); repeat (5) @(posedge clk); `CHK(sr_rate, 2'h2)
        $display("self refresh test done");
        for (int i = 0; i < 3; i++) begin
            mrw(3'h1, 16'(i == 2 ? $urandom % 8 : i * 3)); gap();
            cmds(1); cmds(3);
        end
        $display("latency test done");
        mrw(3'h1, 16'h0080); `CHK(wlvl_q, 1'b1)
        model.term(1'b1);
        repeat (8) begin
            hi = $urandom % 2;
            model.strobe(hi ? 145 + $urandom % 20 : 82 + $urandom % 25);
            repeat (10) @(posedge clk);
            `CHK(dq_out, {DQ_W{hi[0]}})
            `CHK(dqs_oe, 1'b0)
        end
        // Step the strobe delay up until feedback first reads one, then lock
        ofs = 92;
        lock_ofs = 0;
        while (lock_ofs == 0 && ofs < 180) begin
            model.strobe(ofs);
            repeat (10) @(posedge clk);
            if (dq_out[0] === 1'b1) lock_ofs = ofs;
            else ofs += 20;
        end
        `CHK(lock_ofs, 132)
        model.term(1'b0);
        repeat (5) @(posedge clk);
        mrw(3'h1, 16'h0000); `CHK(wlvl_q, 1'b0)
        `CHK(|dq_undef, 1'b1)
        `CHK(&dq_oe, 1'b1)
        // Flag trails the window by its two registers
        gap(); repeat (2) @(posedge clk);
        `CHK({dq_undef, dq_oe}, '0)
        $display("leveling test done");
        end_sim();
    end
    initial begin
        #200000;
        errors++;
        end_sim();
    end
endmodule // ddr_mode_ctl_tb_top
bind ddr_mode_ctl ddr_mode_ctl_monitor #(.DQ_W(DQ_W), .CA_W(CA_W)) mon (.*);
`default_nettype wire
